// >>> core/rtc_ctl_pkg.sv
/*
 * Constants for the clock's output/status/charger control block.
 * Assumes a single 25 MHz reference clock and an external register
 * access port (address, write strobe, write data, read data).
 */
package rtc_ctl_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h0E;
  localparam logic [7:0] ADDR_STATUS  = 8'h0F;
  localparam logic [7:0] ADDR_CHARGER = 8'h10;

  // ************************************************************
  // Control fields
  // ************************************************************
  localparam int CTL_OSC_DIS  = 7;
  localparam int CTL_RATE_HI  = 4;
  localparam int CTL_RATE_LO  = 3;
  localparam int CTL_OUT_SEL  = 2;
  localparam int CTL_A2_IE    = 1;
  localparam int CTL_A1_IE    = 0;
  localparam logic [7:0] CTL_RESET    = 8'h18;
  localparam logic [7:0] CTL_WMASK    = 8'hBF;

  // ************************************************************
  // Status fields
  // ************************************************************
  localparam int STS_OSF = 7;
  localparam int STS_A2F = 1;
  localparam int STS_A1F = 0;

  // ************************************************************
  // Charger fields
  // ************************************************************
  localparam logic [7:0] CHG_RESET = 8'h00;
  localparam logic [3:0] CHG_KEY   = 4'hA;
  localparam int CHG_KEY_HI = 7;
  localparam int CHG_KEY_LO = 4;
  localparam int CHG_DS_HI  = 3;
  localparam int CHG_DS_LO  = 2;
  localparam int CHG_R_HI   = 1;
  localparam int CHG_R_LO   = 0;
  localparam logic [1:0] DS_NONE = 2'h1;
  localparam logic [1:0] DS_ONE  = 2'h2;
  localparam logic [1:0] R_250   = 2'h1;
  localparam logic [1:0] R_2K    = 2'h2;
  localparam logic [1:0] R_4K    = 2'h3;

  // ************************************************************
  // Square-wave rates: half periods in 32.768 kHz ticks, minus one
  // ************************************************************
  localparam logic [1:0]  RATE_1HZ   = 2'h0;
  localparam logic [1:0]  RATE_4K    = 2'h1;
  localparam logic [1:0]  RATE_8K    = 2'h2;
  localparam logic [1:0]  RATE_32K   = 2'h3;
  localparam logic [13:0] HALF_1HZ   = 14'h3FFF;
  localparam logic [13:0] HALF_4K    = 14'h0003;
  localparam logic [13:0] HALF_8K    = 14'h0001;

  typedef enum logic [2:0] {
    OUT_IDLE = 3'h1,
    OUT_WAVE = 3'h2,
    OUT_IRQ  = 3'h4
  } out_state_t;

endpackage

// >>> core/rtc_output_status_charger_ctl.sv
/*
 * Control register, status flags, charger decode and combined
 * square-wave/interrupt output of the clock.
 * Assumes osc_tick and alarm match pulses come from logic on ref_clk;
 * osc_running comes from the oscillator domain and is synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

module rtc_output_status_charger_ctl (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       osc_tick,
  input  wire logic       osc_running,
  input  wire logic       alarm_one_match,
  input  wire logic       alarm_two_match,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            square_irq_out,
  output logic            osc_disable,
  output logic            charger_enable,
  output logic            diode_select,
  output logic      [1:0] resistor_select
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0]  control_r;
  logic [7:0]  charger_select_r;
  logic        osc_stop_flag_r;
  logic        alarm_two_flag_r;
  logic        alarm_one_flag_r;
  logic        osc_meta_r;
  logic        osc_sync_r;
  logic        osc_prev_r;
  logic [13:0] div_cnt_r;
  logic        wave_r;
  rtc_ctl_pkg::out_state_t out_state_r;
  rtc_ctl_pkg::out_state_t out_state_nxt;

  logic wr_ctl;
  logic wr_sts;
  logic wr_chg;
  logic osc_stopped;
  logic irq_active;
  logic [1:0]  rate;
  logic [13:0] half_limit;
  logic [7:0]  status_view;
  logic        chg_on;

  assign wr_ctl = reg_wr && (reg_addr == rtc_ctl_pkg::ADDR_CONTROL);
  assign wr_sts = reg_wr && (reg_addr == rtc_ctl_pkg::ADDR_STATUS);
  assign wr_chg = reg_wr && (reg_addr == rtc_ctl_pkg::ADDR_CHARGER);

  // A write of zero clears; hardware setting in the same cycle wins.
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic wr, input logic wbit);
    flag_next = set | (cur & ~(wr & ~wbit));
  endfunction

  // ************************************************************
  // Control register
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      control_r <= rtc_ctl_pkg::CTL_RESET;
    end else if (wr_ctl) begin
      control_r <= reg_wdata & rtc_ctl_pkg::CTL_WMASK;
    end
  end

  // ************************************************************
  // Oscillator stop detection
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_meta_r <= 1'b0;
      osc_sync_r <= 1'b0;
      osc_prev_r <= 1'b0;
    end else begin
      osc_meta_r <= osc_running;
      osc_sync_r <= osc_meta_r;
      osc_prev_r <= osc_sync_r;
    end
  end

  // Falling edge of running, or software stopping it
  assign osc_stopped = (osc_prev_r && !osc_sync_r) ||
                       (wr_ctl && reg_wdata[rtc_ctl_pkg::CTL_OSC_DIS] &&
                        !control_r[rtc_ctl_pkg::CTL_OSC_DIS]);

  // ************************************************************
  // Status flags
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_stop_flag_r  <= 1'b1;  // first power-up counts as a stop
      alarm_two_flag_r <= 1'b0;
      alarm_one_flag_r <= 1'b0;
    end else begin
      osc_stop_flag_r  <= flag_next(osc_stop_flag_r, osc_stopped, wr_sts,
                                    reg_wdata[rtc_ctl_pkg::STS_OSF]);
      alarm_two_flag_r <= flag_next(alarm_two_flag_r, alarm_two_match, wr_sts,
                                    reg_wdata[rtc_ctl_pkg::STS_A2F]);
      alarm_one_flag_r <= flag_next(alarm_one_flag_r, alarm_one_match, wr_sts,
                                    reg_wdata[rtc_ctl_pkg::STS_A1F]);
    end
  end

  // ************************************************************
  // Charger register and decode
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      charger_select_r <= rtc_ctl_pkg::CHG_RESET;
    end else if (wr_chg) begin
      charger_select_r <= reg_wdata;
    end
  end

  // 250 ohms above 3.63V is left to software; no supply sense here
  always_comb begin
    chg_on = (charger_select_r[rtc_ctl_pkg::CHG_KEY_HI:rtc_ctl_pkg::CHG_KEY_LO]
              == rtc_ctl_pkg::CHG_KEY);
    if ((charger_select_r[rtc_ctl_pkg::CHG_DS_HI:rtc_ctl_pkg::CHG_DS_LO]
         != rtc_ctl_pkg::DS_NONE) &&
        (charger_select_r[rtc_ctl_pkg::CHG_DS_HI:rtc_ctl_pkg::CHG_DS_LO]
         != rtc_ctl_pkg::DS_ONE)) begin
      chg_on = 1'b0;
    end
    if ((charger_select_r[rtc_ctl_pkg::CHG_R_HI:rtc_ctl_pkg::CHG_R_LO]
         != rtc_ctl_pkg::R_250) &&
        (charger_select_r[rtc_ctl_pkg::CHG_R_HI:rtc_ctl_pkg::CHG_R_LO]
         != rtc_ctl_pkg::R_2K) &&
        (charger_select_r[rtc_ctl_pkg::CHG_R_HI:rtc_ctl_pkg::CHG_R_LO]
         != rtc_ctl_pkg::R_4K)) begin
      chg_on = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      charger_enable  <= 1'b0;
      diode_select    <= 1'b0;
      resistor_select <= 2'h0;
    end else begin
      charger_enable  <= chg_on;
      diode_select    <= chg_on &&
                         (charger_select_r[rtc_ctl_pkg::CHG_DS_HI:rtc_ctl_pkg::CHG_DS_LO]
                          == rtc_ctl_pkg::DS_ONE);
      resistor_select <= chg_on ?
                         charger_select_r[rtc_ctl_pkg::CHG_R_HI:rtc_ctl_pkg::CHG_R_LO] :
                         2'h0;
    end
  end

  // ************************************************************
  // Square-wave divider
  // ************************************************************
  assign rate = {control_r[rtc_ctl_pkg::CTL_RATE_HI], control_r[rtc_ctl_pkg::CTL_RATE_LO]};

  always_comb begin
    case (rate)
      rtc_ctl_pkg::RATE_1HZ: half_limit = rtc_ctl_pkg::HALF_1HZ;
      rtc_ctl_pkg::RATE_4K:  half_limit = rtc_ctl_pkg::HALF_4K;
      rtc_ctl_pkg::RATE_8K:  half_limit = rtc_ctl_pkg::HALF_8K;
      default:               half_limit = 14'h0000;
    endcase
  end

  // 32.768 kHz toggles every tick; others count ticks per half period
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt_r <= 14'h0000;
      wave_r    <= 1'b0;
    end else if (osc_tick) begin
      if (rate == rtc_ctl_pkg::RATE_32K) begin
        div_cnt_r <= 14'h0000;
        wave_r    <= ~wave_r;
      end else if (div_cnt_r >= half_limit) begin
        div_cnt_r <= 14'h0000;
        wave_r    <= ~wave_r;
      end else begin
        div_cnt_r <= div_cnt_r + 14'h0001;
      end
    end
  end

  // ************************************************************
  // Output mode and pin
  // ************************************************************
  assign irq_active =
    (alarm_one_flag_r && control_r[rtc_ctl_pkg::CTL_A1_IE]) ||
    (alarm_two_flag_r && control_r[rtc_ctl_pkg::CTL_A2_IE]);

  always_comb begin
    case (out_state_r)
      rtc_ctl_pkg::OUT_IDLE,
      rtc_ctl_pkg::OUT_WAVE,
      rtc_ctl_pkg::OUT_IRQ:
        out_state_nxt = control_r[rtc_ctl_pkg::CTL_OUT_SEL] ?
                        rtc_ctl_pkg::OUT_IRQ : rtc_ctl_pkg::OUT_WAVE;
      default: out_state_nxt = rtc_ctl_pkg::OUT_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      out_state_r <= rtc_ctl_pkg::OUT_IDLE;
    end else begin
      out_state_r <= out_state_nxt;
    end
  end

  // Pin held low until the flag or its interrupt enable bit is cleared, since flags are sticky
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      square_irq_out <= 1'b1;
    end else begin
      case (out_state_nxt)
        rtc_ctl_pkg::OUT_WAVE: square_irq_out <= wave_r;
        rtc_ctl_pkg::OUT_IRQ:  square_irq_out <= ~irq_active;
        default:               square_irq_out <= 1'b1;
      endcase
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  assign status_view = {osc_stop_flag_r, 5'h00, alarm_two_flag_r, alarm_one_flag_r};

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata   <= 8'h00;
      osc_disable <= 1'b0;
    end else begin
      osc_disable <= control_r[rtc_ctl_pkg::CTL_OSC_DIS];
      case (reg_addr)
        rtc_ctl_pkg::ADDR_CONTROL: reg_rdata <= control_r;
        rtc_ctl_pkg::ADDR_STATUS:  reg_rdata <= status_view;  // reserved read zero
        rtc_ctl_pkg::ADDR_CHARGER: reg_rdata <= charger_select_r;
        default:                   reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // rtc_output_status_charger_ctl

`default_nettype wire

// >>> tb/rtc_ctl_asserts.sv
/* Port-level assertions for the control block.
   Assumes it is bound to the block's top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module rtc_ctl_chk (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       osc_tick,
  input wire logic       alarm_one_match,
  input wire logic       alarm_two_match,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       square_irq_out,
  input wire logic       charger_enable,
  input wire logic [1:0] resistor_select
);
  // ****************************
  // Control shadow
  // ****************************
  logic [7:0] ctl_r;
  wire logic  sts_a = reg_addr == rtc_ctl_pkg::ADDR_STATUS;
  // Key 1010, diode 01/10, resistor not 00
  wire logic  ok = reg_wdata[7:4] == 4'hA && ^reg_wdata[3:2] && |reg_wdata[1:0];
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn)
      ctl_r <= rtc_ctl_pkg::CTL_RESET;
    else if (reg_wr && reg_addr == rtc_ctl_pkg::ADDR_CONTROL)
      ctl_r <= reg_wdata & rtc_ctl_pkg::CTL_WMASK;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // ****************************
  // Properties
  // ****************************
  chk_rsvd_zero:
    assert property ($past(sts_a) |-> reg_rdata[6:2] == 5'h00) else $error("reserved bits set");
  chk_stop_hold:
    assert property (sts_a && $past(sts_a) && reg_rdata[7] && !$past(reg_wr) |=> reg_rdata[7])
    else $error("stop flag dropped");
  chk_chg_decode:
    assert property (reg_wr && reg_addr == rtc_ctl_pkg::ADDR_CHARGER |-> ##2
      charger_enable == $past(ok, 2) &&
      resistor_select == ($past(ok, 2) ? $past(reg_wdata[1:0], 2) : 2'h0))
    else $error("charger decode wrong");
  chk_irq_one:
    assert property (alarm_one_match && ctl_r[2] && ctl_r[0] && !reg_wr |-> ##[1:2] !square_irq_out)
    else $error("alarm one not signalled");
  chk_irq_hold:
    assert property (ctl_r[2] && !square_irq_out && !$past(reg_wr) |=> !square_irq_out)
    else $error("interrupt released early");
  chk_irq_masked:
    assert property (ctl_r[2:0] == 3'h4 && $stable(ctl_r) |-> square_irq_out)
    else $error("masked alarm drove pin");
  chk_wave_toggle:
    assert property (!ctl_r[2] && ctl_r[4:3] == 2'h3 && osc_tick && $stable(ctl_r)
      |=> ##1 $changed(square_irq_out)) else $error("wave did not toggle");
  chk_flag_clear:
    assert property (ctl_r[2] && reg_wr && sts_a && reg_wdata[1:0] == 2'h0 && !alarm_one_match
      && !alarm_two_match |-> ##2 square_irq_out) else $error("pin low after clear");
  cover property (ctl_r[2] && !square_irq_out);
  cover property (!ctl_r[2] && osc_tick);
  cover property (charger_enable);
endmodule // rtc_ctl_chk
bind rtc_output_status_charger_ctl rtc_ctl_chk i_rtc_ctl_chk (.ref_clk, .resetn, .osc_tick,
  .alarm_one_match, .alarm_two_match, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
  .square_irq_out, .charger_enable, .resistor_select);
`default_nettype wire

// >>> tb/rtc_osc_model.sv
/* Oscillator model: tick source and running level.
   Assumes the bench gates it with run; the block's disable stops it. */
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model #(parameter int DIV = 4) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic run,
  input  wire logic osc_disable,
  output logic      osc_tick,
  output logic      osc_running
);
  logic [7:0] cnt_r;
  assign osc_running = run && !osc_disable;
  // Ticks stop dead while stopped, as a real crystal would
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 8'h00;
      osc_tick <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == 8'(DIV - 1)) ? 8'h00 : cnt_r + 8'h01;
      osc_tick <= osc_running && cnt_r == 8'(DIV - 1);
    end
  end
endmodule // rtc_osc_model
`default_nettype wire

// >>> tb/rtc_output_status_charger_ctl_bench.sv
/* Self-checking bench with a register model.
   Assumes the checker is bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
module rtc_output_status_charger_ctl_bench;
  logic       ref_clk = 1'b0, resetn = 1'b0, run = 1'b1, a1 = 1'b0, a2 = 1'b0, reg_wr = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic       pin, osc_tick, osc_running, osc_disable, chg_en, dsel;
  logic [1:0] rsel;
  int         n_mismatch = 0, checked = 0, ctl_m = 'h18, sts_m = 'h80, chg_m = 0, n, e;
  always #20 ref_clk = ~ref_clk;
  rtc_osc_model i_rtc_osc_model (.ref_clk, .resetn, .run, .osc_disable, .osc_tick, .osc_running);
  rtc_output_status_charger_ctl i_rtc_output_status_charger_ctl (.ref_clk, .resetn, .osc_tick,
    .osc_running, .alarm_one_match(a1), .alarm_two_match(a2), .reg_addr, .reg_wr, .reg_wdata,
    .reg_rdata, .square_irq_out(pin), .osc_disable, .charger_enable(chg_en),
    .diode_select(dsel), .resistor_select(rsel));
  // ****************************
  // Helpers
  // ****************************
  task automatic cmp(string what, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    if (a == 8'h0E) ctl_m = v & 8'hBF;
    if (a == 8'h0E && v[7]) sts_m = sts_m | 'h80;
    if (a == 8'h0F) sts_m = sts_m & (v | 8'h7C);
    if (a == 8'h10) chg_m = v;
  endtask
  task automatic rd(logic [7:0] a, int exp);
    reg_addr = a;
    tick(2);
    cmp("reg_rdata", reg_rdata, 8'(exp));
  endtask
  // Pin and status after an action in interrupt mode
  task automatic settle();
    tick(2);
    cmp("square_irq_out", 8'(pin), 8'((sts_m & ctl_m & 3) == 0));
    rd(8'h0F, sts_m);
  endtask
  task automatic alarm(logic one, logic two);
    a1 = one;
    a2 = two;
    tick(1);
    a1 = 1'b0;
    a2 = 1'b0;
    sts_m = sts_m | (one ? 1 : 0) | (two ? 2 : 0);
    settle();
  endtask
  // ****************************
  // Scenarios
  // ****************************
  initial begin
    void'($urandom(43033));
    tick(2);
    resetn = 1'b1;
    tick(1);
    rd(8'h0E, ctl_m);
    rd(8'h0F, sts_m);
    rd(8'h10, 0);
    for (int r = 3; r >= 0; r--) begin
      wr(8'h0E, 8'(r << 3));
      n = 0;
      e = (r == 0) ? 0 : 32 >> (3 - r);
      repeat (128) begin
        d[0] = pin;
        tick(1);
        n += (pin !== d[0]) ? 1 : 0;
      end
      cmp("wave toggles", 8'(n + 1 >= e && n <= e + 1), 8'h01);
    end
    wr(8'h0F, 8'hFF);
    rd(8'h0F, sts_m);
    wr(8'h0F, 8'h00);
    rd(8'h0F, sts_m);
    run = 1'b0;
    tick(6);
    sts_m = sts_m | 'h80;
    rd(8'h0F, sts_m);
    run = 1'b1;
    wr(8'h0F, 8'h00);
    wr(8'h0E, 8'h80);
    rd(8'h0F, sts_m);
    cmp("osc_disable", 8'(osc_disable), 8'h01);
    wr(8'h0E, 8'h05);
    alarm(1'b0, 1'b1);
    alarm(1'b1, 1'b0);
    tick(20);
    settle();
    wr(8'h0F, 8'hFE);
    settle();
    wr(8'h0E, 8'h06);
    settle();
    alarm(1'b1, 1'b1);
    wr(8'h0E, 8'h04);
    settle();
    wr(8'h0F, 8'h00);
    settle();
    // Supply held below the low-resistor limit, so 250 ohm codes are legal
    for (int k = 0; k < 40; k++) begin
      d = (k < 16) ? {4'hA, 4'(k)} : 8'($urandom);
      wr(8'h10, d);
      tick(2);
      e = (d[7:4] == 4'hA && ^d[3:2] && |d[1:0]) ? {2'b01, d[3:2] == 2'h2, d[1:0]} : 0;
      cmp("charger outputs", {4'h0, chg_en, dsel, rsel}, 8'(e));
      rd(8'h10, chg_m);
    end
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule // rtc_output_status_charger_ctl_bench
`default_nettype wire
